// file: xcvr_spi_map.svh
`ifndef XCVR_SPI_MAP_SVH
`define XCVR_SPI_MAP_SVH

// Serial framing.
`define SPI_BYTE_W 8
`define MIN_BURSTS 3
`define MIN_PAYLOAD_BYTES 2

// Header layout: read flag on top, resource address in the low bits.
`define HDR_RD_BIT 7
`define HDR_ADDR_MSB 5
`define HDR_ADDR_LSB 0

// Control word that switches the two general pins to indicator duty.
`define GPIO_CTRL_REG 9
`define GPIO_ALT_BIT 7

// Default contents of every port register after reset.
`define REG_RESET_VAL 16'h0000

// Timing.
`define CLK_PERIOD_NS 8
`define SCLK_PERIOD_NS 125
`define SCLK_HALF_CYC \
  ((`SCLK_PERIOD_NS + 2 * `CLK_PERIOD_NS - 1) / (2 * `CLK_PERIOD_NS))
`define RST_MIN_NS 250
`define RST_MIN_CYC \
  ((`RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: spi_port_pkg.sv
`include "xcvr_spi_map.svh"

package spi_port_pkg;

  typedef logic [`HDR_ADDR_MSB-`HDR_ADDR_LSB:0] res_addr_t;

  typedef enum logic [1:0] {
    DS_WAIT = 2'b00,
    DS_HEAD = 2'b01,
    DS_DATA = 2'b11,
    DS_SKIP = 2'b10
  } dev_st_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_LOW = 3'b001,
    HS_HIGH = 3'b011,
    HS_HOLD = 3'b010
  } host_st_t;

  function automatic logic header_is_read(input logic [7:0] hdr);
    return hdr[`HDR_RD_BIT];
  endfunction

  function automatic res_addr_t header_addr(input logic [7:0] hdr);
    return hdr[`HDR_ADDR_MSB:`HDR_ADDR_LSB];
  endfunction

  function automatic logic [7:0] make_header(input logic rd,
                                             input res_addr_t addr);
    logic [7:0] h;
    h = 8'h00;
    h[`HDR_RD_BIT] = rd;
    h[`HDR_ADDR_MSB:`HDR_ADDR_LSB] = addr;
    return h;
  endfunction

endpackage

// file: spi_link_if.sv
`timescale 1ns/1ns

interface spi_link_if;
  logic sclk;
  logic ce_n;
  logic mosi;
  logic miso;
  logic miso_oe;

  modport dev (
    input sclk,
    input ce_n,
    input mosi,
    output miso,
    output miso_oe
  );

  modport host (
    output sclk,
    output ce_n,
    output mosi,
    input miso,
    input miso_oe
  );
endinterface

// file: byte_shift_in.sv
`timescale 1ns/1ns

module byte_shift_in #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Control.
  input wire logic clear,
  input wire logic sample,
  input wire logic bit_in,
  // Result.
  output logic [W-1:0] data_q,
  output logic done_q
);
  localparam int CW = $clog2(W);

  if (W < 2) begin : g_chk
    $error("byte_shift_in needs at least two bits");
  end

  typedef struct packed {
    logic [W-1:0] data;
    logic [CW-1:0] cnt;
    logic done;
  } shift_state_t;

  shift_state_t s_q;
  shift_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (clear) begin
      s_d.cnt = '0;
    end else if (sample) begin
      // MSB arrives first, so shift toward the top.
      s_d.data = {s_q.data[W-2:0], bit_in};
      if (s_q.cnt == CW'(W - 1)) begin
        s_d.cnt = '0;
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign data_q = s_q.data;
  assign done_q = s_q.done;
endmodule

// file: xcvr_spi_dev.sv
`timescale 1ns/1ns

`include "xcvr_spi_map.svh"

// Contract
// - Slave only, never drives clock or starts
// - Host supplies serial clock every transfer
// - Sample on rise, change output on fall
// - Host uses phase zero, idle-low clock
// - Eight-bit bursts, most significant bit first
// - Chip enable low opens each transaction
// - At least three bursts per transaction
// - First burst header: read flag, address
// - Write data on MOSI, read on MISO
// - Only one line carries data per burst
// - Payload holds at least two bytes
// - Payload byte count is always even
// - Chip enable rising ends the transaction
// - Static port, core clock moves words
// - Alternate enable drives CRC valid pin
// - Alternate enable drives out-of-idle pin
// - Reset low: off, contents lost
// - Reset release: idle with default registers
// - Accept transactions only in idle mode
module xcvr_spi_dev import spi_port_pkg::*; #(
  parameter int ADDR_W = 6,
  parameter int BYTE_W = 8,
  parameter int DATA_W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Serial link.
  spi_link_if.dev link,
  // Mode and radio status.
  input wire logic sleep_req,
  input wire logic crc_valid_in,
  input wire logic out_of_idle_in,
  // General pins.
  input wire logic general_pin_one_in,
  output logic general_pin_one_out,
  output logic general_pin_one_oe,
  input wire logic general_pin_two_in,
  output logic general_pin_two_out,
  output logic general_pin_two_oe,
  output logic [1:0] pin_level,
  // Committed write report and port activity.
  output logic wr_strobe,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data,
  output logic port_active
);
  localparam int NW = 1 << ADDR_W;
  localparam int TCW = $clog2(BYTE_W);

  if (BYTE_W != `SPI_BYTE_W || DATA_W != 2 * BYTE_W ||
      ADDR_W != `HDR_ADDR_MSB - `HDR_ADDR_LSB + 1) begin : g_chk
    $error("xcvr_spi_dev widths do not match the header layout");
  end

  localparam logic [NW-1:0][DATA_W-1:0] REGS_RST =
    {NW{DATA_W'(`REG_RESET_VAL)}};

  typedef struct packed {
    dev_st_t st;
    logic sclk;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic have_hi;
    logic [BYTE_W-1:0] hi;
    logic [BYTE_W-1:0] txsh;
    logic [TCW-1:0] tx_cnt;
    logic tx_lo;
    logic miso;
    logic miso_oe;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic [1:0] pin_in;
    logic wr;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [NW-1:0][DATA_W-1:0] regs;
  } dev_state_t;

  dev_state_t s_q;
  dev_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////

  logic rise;
  logic fall;
  logic rx_clear;
  logic [BYTE_W-1:0] rx_byte;
  logic rx_done;

  // The serial clock is sampled like any other input; edges are found by
  // comparing with last cycle, so no logic runs on the host's clock.
  assign rise = link.sclk & ~s_q.sclk;
  assign fall = ~link.sclk & s_q.sclk;
  assign rx_clear = link.ce_n | (s_q.st == DS_WAIT);

  byte_shift_in #(
    .W(BYTE_W)
  ) byte_shift_in_i (
    .clk(clk),
    .nrst(nrst),
    .clear(rx_clear),
    .sample(rise),
    .bit_in(link.mosi),
    .data_q(rx_byte),
    .done_q(rx_done)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic alt;
    logic [1:0] ind;
    logic [BYTE_W-1:0] nxt;
    alt = 1'b0;
    ind = 2'b00;
    nxt = '0;
    s_d = s_q;
    s_d.sclk = link.sclk;
    s_d.wr = 1'b0;

    case (s_q.st)
      DS_WAIT: begin
        s_d.have_hi = 1'b0;
        s_d.tx_cnt = '0;
        s_d.tx_lo = 1'b0;
        if (!link.ce_n) begin
          // Frames opened while asleep are let run by untouched.
          s_d.st = sleep_req ? DS_SKIP : DS_HEAD;
        end
      end
      DS_HEAD: begin
        if (rx_done) begin
          s_d.rd = header_is_read(rx_byte);
          s_d.addr = header_addr(rx_byte);
          s_d.st = DS_DATA;
        end
      end
      DS_DATA: begin
        if (s_q.rd) begin
          if (fall) begin
            // Next bit goes out on the falling edge, ahead of its rise.
            if (s_q.tx_cnt == '0) begin
              nxt = s_q.tx_lo ? s_q.regs[s_q.addr][BYTE_W-1:0]
                              : s_q.regs[s_q.addr][DATA_W-1:BYTE_W];
              s_d.miso = nxt[BYTE_W-1];
              s_d.txsh = {nxt[BYTE_W-2:0], 1'b0};
            end else begin
              s_d.miso = s_q.txsh[BYTE_W-1];
              s_d.txsh = {s_q.txsh[BYTE_W-2:0], 1'b0};
            end
            if (s_q.tx_cnt == TCW'(BYTE_W - 1)) begin
              s_d.tx_cnt = '0;
              s_d.tx_lo = ~s_q.tx_lo;
              if (s_q.tx_lo) begin
                s_d.addr = s_q.addr + ADDR_W'(1);
              end
            end else begin
              s_d.tx_cnt = s_q.tx_cnt + TCW'(1);
            end
          end
        end else if (rx_done) begin
          // Bytes pair into words; only a whole pair is committed.
          if (!s_q.have_hi) begin
            s_d.hi = rx_byte;
            s_d.have_hi = 1'b1;
          end else begin
            s_d.have_hi = 1'b0;
            s_d.regs[s_q.addr] = {s_q.hi, rx_byte};
            s_d.wr = 1'b1;
            s_d.wr_addr = s_q.addr;
            s_d.wr_data = {s_q.hi, rx_byte};
            s_d.addr = s_q.addr + ADDR_W'(1);
          end
        end
      end
      DS_SKIP: begin
        s_d.st = DS_SKIP;
      end
      default: begin
        s_d.st = DS_WAIT;
      end
    endcase

    // Rising chip enable ends the frame; a lone high byte is dropped.
    if (link.ce_n) begin
      s_d.st = DS_WAIT;
      s_d.have_hi = 1'b0;
    end

    // MISO is driven only in the payload of a read.
    s_d.miso_oe = !link.ce_n && s_q.st == DS_DATA && s_q.rd;
    if (!s_d.miso_oe) begin
      s_d.miso = 1'b0;
    end

    alt = s_q.regs[`GPIO_CTRL_REG][`GPIO_ALT_BIT];
    ind = {crc_valid_in, out_of_idle_in};
    for (int i = 0; i < 2; i++) begin
      s_d.pin_oe[i] = alt;
      s_d.pin_out[i] = alt & ind[i];
    end
    s_d.pin_in = {general_pin_two_in, general_pin_one_in};
  end

  ////////////////////////////////////////////////////////////////////////////

  // Reset clears every register to its default and leaves the port idle.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.regs <= REGS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.miso = s_q.miso;
  assign link.miso_oe = s_q.miso_oe;
  assign general_pin_one_out = s_q.pin_out[0];
  assign general_pin_one_oe = s_q.pin_oe[0];
  assign general_pin_two_out = s_q.pin_out[1];
  assign general_pin_two_oe = s_q.pin_oe[1];
  assign pin_level = s_q.pin_in;
  assign wr_strobe = s_q.wr;
  assign wr_addr = s_q.wr_addr;
  assign wr_data = s_q.wr_data;
  assign port_active = s_q.st[0];
endmodule

// file: xcvr_spi_host.sv
`timescale 1ns/1ns

`include "xcvr_spi_map.svh"

module xcvr_spi_host import spi_port_pkg::*; #(
  parameter int HALF_CYC = `SCLK_HALF_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Serial link.
  spi_link_if.host link,
  // Command.
  input wire logic start,
  input wire logic rd,
  input wire res_addr_t addr,
  input wire logic [15:0] wdata,
  // Answer.
  output logic busy,
  output logic done,
  output logic [15:0] rdata
);
  localparam int FRAME_BITS = `MIN_BURSTS * `SPI_BYTE_W;
  localparam int CNT_W = 8;
  localparam int BIT_W = 5;

  // The device finds edges one cycle late and answers one cycle after a
  // fall, so a half period below two cycles would starve its data line.
  if (HALF_CYC < 2 || HALF_CYC > 255) begin : g_chk
    $error("xcvr_spi_host half period out of range");
  end

  typedef struct packed {
    host_st_t st;
    logic [CNT_W-1:0] cnt;
    logic [BIT_W-1:0] bits;
    logic [FRAME_BITS-1:0] frame;
    logic [15:0] rdata;
    logic sclk;
    logic ce_n;
    logic mosi;
    logic busy;
    logic done;
  } host_state_t;

  host_state_t s_q;
  host_state_t s_d;

  logic half_end;
  assign half_end = s_q.cnt == CNT_W'(HALF_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.cnt = half_end ? '0 : s_q.cnt + CNT_W'(1);
    case (s_q.st)
      HS_IDLE: begin
        s_d.cnt = '0;
        if (start) begin
          // Header then one 16-bit word; the low phase gives CE setup.
          s_d.frame = {make_header(rd, addr), rd ? 16'h0000 : wdata};
          s_d.mosi = s_d.frame[FRAME_BITS-1];
          s_d.ce_n = 1'b0;
          s_d.busy = 1'b1;
          s_d.bits = '0;
          s_d.st = HS_LOW;
        end
      end
      HS_LOW: begin
        if (half_end) begin
          s_d.sclk = 1'b1;
          s_d.rdata = {s_q.rdata[14:0], link.miso};
          s_d.st = HS_HIGH;
        end
      end
      HS_HIGH: begin
        if (half_end) begin
          s_d.sclk = 1'b0;
          s_d.frame = {s_q.frame[FRAME_BITS-2:0], 1'b0};
          s_d.mosi = s_q.frame[FRAME_BITS-2];
          s_d.bits = s_q.bits + BIT_W'(1);
          s_d.st = (s_q.bits == BIT_W'(FRAME_BITS - 1)) ? HS_HOLD : HS_LOW;
        end
      end
      HS_HOLD: begin
        s_d.mosi = 1'b0;
        if (half_end) begin
          s_d.ce_n = 1'b1;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.st = HS_IDLE;
        end
      end
      default: begin
        s_d.st = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.ce_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.sclk = s_q.sclk;
  assign link.ce_n = s_q.ce_n;
  assign link.mosi = s_q.mosi;
  assign busy = s_q.busy;
  assign done = s_q.done;
  assign rdata = s_q.rdata;
endmodule

// file: spi_link_checker.sv
`timescale 1ns/1ns

module spi_link_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Serial link.
  input wire logic sclk,
  input wire logic ce_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  typedef struct packed {
    logic sclk;
    logic [4:0] bits;
    logic [7:0] hdr;
  } mon_t;
  mon_t st_q;
  mon_t st_d;

  // Edges are seen on clk, so every serial half must span two cycles.
  always_comb begin
    st_d = st_q;
    st_d.sclk = sclk;
    if (ce_n) begin
      st_d.bits = 5'd0;
      st_d.hdr = 8'h00;
    end else if (sclk && !st_q.sclk) begin
      st_d.bits = st_q.bits + 5'd1;
      if (st_q.bits < 5'd8) st_d.hdr = {st_q.hdr[6:0], mosi};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) st_q <= '0;
    else st_q <= st_d;
  end

  ////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_idle_clock_low: assert property (ce_n |-> !sclk)
    else $error("serial clock high outside a frame");
  a_ce_setup_low: assert property ($fell(ce_n) |-> !sclk ##1 !sclk)
    else $error("clock rose too soon after chip enable");
  a_sclk_half_width: assert property ($changed(sclk) |=> $stable(sclk))
    else $error("serial clock half too short");
  a_mosi_on_fall: assert property (
    $changed(mosi) |-> $fell(sclk) || $changed(ce_n))
    else $error("host data moved off a falling edge");
  a_miso_on_fall: assert property (!ce_n && $changed(miso) |-> !sclk)
    else $error("device data moved while clock high");
  a_frame_bit_count: assert property (
    $rose(ce_n) |-> st_q.bits == 5'd24)
    else $error("frame did not carry 24 bits");
  a_oe_read_only: assert property (
    miso_oe && !ce_n |-> st_q.bits >= 5'd8 && st_q.hdr[7])
    else $error("device drove data outside a read payload");
  a_oe_off_idle: assert property (
    ce_n && $past(ce_n) |-> !miso_oe && !miso)
    else $error("device data line active between frames");
endmodule

// file: transceiver_spi_slave_port_tb.sv
`timescale 1ns/1ns

module transceiver_spi_slave_port_tb import spi_port_pkg::*;;
  logic clk, nrst, start, rd, busy, done, sleep_req, alt;
  logic crc_valid_in, out_of_idle_in, wr_strobe, port_active;
  logic general_pin_one_in, general_pin_one_out, general_pin_one_oe;
  logic general_pin_two_in, general_pin_two_out, general_pin_two_oe;
  logic [1:0] pin_level;
  res_addr_t addr, a;
  logic [5:0] wr_addr;
  logic [15:0] wdata, rdata, wr_data;
  logic [15:0] mem [64];
  logic [16:0] rd_q [$];
  logic [21:0] wr_q [$];
  logic [16:0] e;
  int error_cnt = 0;
  int checked = 0;

  spi_link_if spi_link_if_i ();
  xcvr_spi_host #(.HALF_CYC(2)) xcvr_spi_host_i (.clk, .nrst,
    .link(spi_link_if_i), .start, .rd, .addr, .wdata, .busy, .done, .rdata);
  xcvr_spi_dev xcvr_spi_dev_i (.clk, .nrst, .link(spi_link_if_i), .sleep_req,
    .crc_valid_in, .out_of_idle_in, .general_pin_one_in, .general_pin_one_out,
    .general_pin_one_oe, .general_pin_two_in, .general_pin_two_out,
    .general_pin_two_oe, .pin_level, .wr_strobe, .wr_addr, .wr_data,
    .port_active);
  spi_link_checker spi_link_checker_i (.clk, .nrst,
    .sclk(spi_link_if_i.sclk), .ce_n(spi_link_if_i.ce_n),
    .mosi(spi_link_if_i.mosi), .miso(spi_link_if_i.miso),
    .miso_oe(spi_link_if_i.miso_oe));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic do_reset();
    nrst = 1'b0;
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    foreach (mem[i]) mem[i] = 16'h0000;
  endtask

  // A sleeping device must neither commit nor answer, so reads expect zero.
  task automatic xfer(input logic r, input res_addr_t ad,
                      input logic [15:0] d, input logic live);
    int n;
    n = 0;
    rd_q.push_back({r, live ? mem[ad] : 16'h0000});
    if (live && !r) begin
      wr_q.push_back({ad, d});
      mem[ad] = d;
    end
    rd = r;
    addr = ad;
    wdata = d;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    check(22'(busy), 22'd1);
    @(posedge clk);
    #1 check(22'(port_active), 22'(live));
    while (done !== 1'b1) begin
      @(posedge clk);
      #1 n++;
      if (n > 300) begin
        check(22'd0, 22'd1);
        conclude();
      end
    end
    check(22'(busy), 22'd0);
  endtask

  always @(posedge clk) begin
    if (nrst && done) begin
      if (rd_q.size() == 0) check(22'd0, 22'd1);
      else begin
        e = rd_q.pop_front();
        if (e[16]) check(22'(rdata), 22'(e[15:0]));
      end
    end
    if (nrst && wr_strobe) begin
      if (wr_q.size() == 0) check(22'd0, 22'd1);
      else check({wr_addr, wr_data}, wr_q.pop_front());
    end
  end

  ////////////////////////////////////////
  initial begin
    {start, rd, addr, wdata, sleep_req, crc_valid_in} = '0;
    {out_of_idle_in, general_pin_one_in, general_pin_two_in} = 3'b000;
    void'($urandom(32'he493_307e));
    do_reset();
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($urandom);
      xfer(1'b0, a, 16'($urandom), 1'b1);
      xfer(1'b1, a, 16'h0000, 1'b1);
    end
    $display("test write_read done");
    for (int i = 0; i < 4; i++) begin
      alt = i[0];
      xfer(1'b0, 6'd9, {8'($urandom), alt, 7'($urandom)}, 1'b1);
      repeat (4) begin
        {crc_valid_in, out_of_idle_in, general_pin_one_in,
         general_pin_two_in} = 4'($urandom);
        @(posedge clk);
        #1 check(22'({general_pin_two_out, general_pin_two_oe,
          general_pin_one_out, general_pin_one_oe, pin_level}),
          22'({alt & crc_valid_in, alt, alt & out_of_idle_in, alt,
          general_pin_two_in, general_pin_one_in}));
      end
    end
    $display("test pins done");
    sleep_req = 1'b1;
    xfer(1'b0, 6'h05, 16'($urandom), 1'b0);
    xfer(1'b1, 6'h05, 16'h0000, 1'b0);
    sleep_req = 1'b0;
    xfer(1'b1, 6'h05, 16'h0000, 1'b1);
    $display("test sleep done");
    a = 6'($urandom);
    xfer(1'b0, a, 16'($urandom) | 16'h0001, 1'b1);
    rd = 1'b0;
    wdata = 16'hffff;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    repeat (40) @(posedge clk);
    #1 do_reset();
    rd_q.delete();
    xfer(1'b1, a, 16'h0000, 1'b1);
    xfer(1'b1, 6'd9, 16'h0000, 1'b1);
    $display("test reset done");
    @(posedge clk);
    #1 check(22'(rd_q.size() + wr_q.size()), 22'd0);
    conclude();
  end
endmodule
